/* rtl/ufb_uart_regs.vh */
// constants of the fractional-baud serial port: control fields, line fields, status bits, counts
`ifndef UFB_UART_REGS_VH
`define UFB_UART_REGS_VH

// ==========================================================
// serial_control_reg fields
`define UFB_CTL_EN       0
`define UFB_CTL_EOT      4
`define UFB_CTL_HSE      5
`define UFB_CTL_TXE      8
`define UFB_CTL_RXE      9
`define UFB_CTL_RESET    16'h0300

// ==========================================================
// line_control_high fields
`define UFB_LCR_PEN      1
`define UFB_LCR_EPS      2
`define UFB_LCR_STP2     3
`define UFB_LCR_WLEN_HI  6
`define UFB_LCR_WLEN_LO  5
`define UFB_LINE_RESET   30'h0000_0000

// ==========================================================
// interrupt status bit positions
`define UFB_INT_RX       0
`define UFB_INT_TX       1
`define UFB_INT_RT       2
`define UFB_INT_FE       3
`define UFB_INT_PE       4
`define UFB_INT_BE       5
`define UFB_INT_OE       6

// ==========================================================
// receive entry status bits above the data byte
`define UFB_RXE_FE       8
`define UFB_RXE_PE       9
`define UFB_RXE_BE       10
`define UFB_RXE_OE       11

// ==========================================================
// counts
`define UFB_RT_BITS      6'h20
`define UFB_OS16_LAST    4'hf
`define UFB_OS16_HALF    4'h7
`define UFB_OS8_LAST     4'h7
`define UFB_OS8_HALF     4'h3
`define UFB_LVL_0        5'h02
`define UFB_LVL_1        5'h04
`define UFB_LVL_2        5'h08
`define UFB_LVL_3        5'h0c
`define UFB_LVL_4        5'h0e

`endif

/* rtl/ufb_fifo.v */
// character FIFO with registered read data, used for both directions
`timescale 1ns/1ps
module ufb_fifo #(
	parameter W     = 12,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire          mclk,
	input  wire          rst_b,
	input  wire          wr,
	input  wire [W-1:0]  wdata,
	input  wire          rd,
	output reg  [W-1:0]  rdata,
	output reg  [AW:0]   count,
	output reg           full,
	output reg           empty
);
	reg  [W-1:0]  mem [0:DEPTH-1];
	reg  [AW-1:0] wp;
	reg  [AW-1:0] rp;
	wire          do_wr = wr & ~full;
	wire          do_rd = rd & ~empty;
	wire [AW:0]   next_count = count + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};

	always @(posedge mclk) begin
		if (do_wr) begin
			mem[wp] <= wdata;
		end
	end

	always @(posedge mclk) begin
		if (!rst_b) begin
			wp    <= {AW{1'b0}};
			rp    <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
			full  <= 1'b0;
			empty <= 1'b1;
			rdata <= {W{1'b0}};
		end else begin
			if (do_wr) begin
				wp <= wp + 1'b1;
			end
			if (do_rd) begin
				rp    <= rp + 1'b1;
				rdata <= mem[rp];
			end
			count <= next_count;
			full  <= (next_count == DEPTH);
			empty <= (next_count == {(AW+1){1'b0}});
		end
	end
endmodule // ufb_fifo

/* rtl/ufb_baud.v */
// fractional baud divider producing the oversampling reference enable
`timescale 1ns/1ps
module ufb_baud #(
	parameter IW = 16,
	parameter FW = 6
) (
	input  wire          mclk,
	input  wire          rst_b,
	input  wire [IW-1:0] ibrd,
	input  wire [FW-1:0] fbrd,
	output reg           tick
);
	reg  [IW:0]  cnt;
	reg  [FW-1:0] acc;
	// carry of the fraction stretches one period in 64ths of a cycle on average
	wire [FW:0]  sum = {1'b0, acc} + {1'b0, fbrd};

	always @(posedge mclk) begin
		if (!rst_b) begin
			cnt  <= {(IW+1){1'b0}};
			acc  <= {FW{1'b0}};
			tick <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (ibrd == {IW{1'b0}}) begin
				cnt <= {(IW+1){1'b0}};
			end else if (cnt <= {{IW{1'b0}}, 1'b1}) begin
				tick <= 1'b1;
				acc  <= sum[FW-1:0];
				cnt  <= {1'b0, ibrd} + {{IW{1'b0}}, sum[FW]};
			end else begin
				cnt <= cnt - 1'b1;
			end
		end
	end
endmodule // ufb_baud

/* rtl/ufb_uart.v */
// fractional-baud serial transmitter/receiver with FIFOs and interrupt status
// Operation
// - transmit and receive each have an enable; both come out of reset set
// - a character in flight is finished even when the module is disabled
// - baud divisor is 16-bit integer plus 6-bit fraction, 22 bits
// - reference runs at 16x baud, or 8x with high speed sampling set
// - divisors and line settings latch together only when line control is written
// - frame is start, data LSB first, optional parity, then stop bits
// - both FIFOs hold 16 characters; receive entries add four error bits
// - while enabled, characters leave the transmit FIFO back to back until empty
// - busy sets on nonempty transmit FIFO, clears after last stop bit
// - start bit is accepted only if still low at mid start bit
// - data bits are sampled one bit period apart after a valid start
// - parity checked if enabled, stop bit must be high, entry stored with errors
// - sources: overrun, break, parity, framing, timeout, transmit level or end of transmission
// - receive interrupt raised at the selected receive FIFO fill level
// - all sources ORed onto one line, each gated by its mask bit
// - raw status readable regardless of mask; masked status readable too
// - writing one to a clear bit clears that source; zero does nothing
// - timeout raised after 32 idle bit periods with data; cleared by empty or clear
`timescale 1ns/1ps
`include "ufb_uart_regs.vh"
module ufb_uart #(
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire        mclk,
	input  wire        rst_b,
	input  wire        ctl_we,
	input  wire [15:0] ctl_wdata,
	input  wire        lcrh_we,
	input  wire [7:0]  lcrh_wdata,
	input  wire [15:0] baud_integer_divisor,
	input  wire [5:0]  baud_fraction_divisor,
	input  wire [2:0]  tx_fifo_level_select,
	input  wire [2:0]  rx_fifo_level_select,
	input  wire [6:0]  interrupt_mask_reg,
	input  wire        int_clear_we,
	input  wire [6:0]  interrupt_clear_reg,
	input  wire        tx_wr,
	input  wire [7:0]  tx_wdata,
	input  wire        rx_rd,
	input  wire        serial_receive_line,
	output reg         serial_transmit_line,
	output wire        tx_full,
	output wire        tx_empty,
	output wire        rx_full,
	output wire        rx_empty,
	output wire [11:0] rx_rdata,
	output reg         busy,
	output reg  [15:0] serial_control_reg,
	output reg  [6:0]  raw_status_reg,
	output reg  [6:0]  masked_status_reg,
	output reg         irq
);
	// ==========================================================
	// state codes
	localparam [5:0] T_IDLE  = 6'h01;
	localparam [5:0] T_LOAD  = 6'h02;
	localparam [5:0] T_START = 6'h04;
	localparam [5:0] T_DATA  = 6'h08;
	localparam [5:0] T_PAR   = 6'h10;
	localparam [5:0] T_STOP  = 6'h20;
	localparam [4:0] R_IDLE  = 5'h01;
	localparam [4:0] R_START = 5'h02;
	localparam [4:0] R_DATA  = 5'h04;
	localparam [4:0] R_PAR   = 5'h08;
	localparam [4:0] R_STOP  = 5'h10;

	// ==========================================================
	// declarations
	reg  [29:0]   line_cfg;
	reg  [5:0]    tx_st;
	reg  [3:0]    tx_sub;
	reg  [2:0]    tx_bit;
	reg  [7:0]    tx_sh;
	reg           tx_par;
	reg           tx_stop2;
	reg           tx_rd;
	reg           tx_done;
	reg  [4:0]    rx_st;
	reg  [3:0]    rx_sub;
	reg  [2:0]    rx_bit;
	reg  [7:0]    rx_sh;
	reg           rx_pbit;
	reg           rx_perr;
	reg           rx_prev;
	reg           rx_wr;
	reg  [11:0]   rx_wdata;
	reg           oe_pend;
	reg  [3:0]    rt_sub;
	reg  [5:0]    rt_cnt;
	reg  [3:0]    ev_err;
	reg           ev_rt;
	reg  [1:0]    ev_lvl;
	reg           tx_lvl_d;
	reg           rx_lvl_d;
	reg  [6:0]    next_raw;
	wire          tick;
	wire [7:0]    tx_q;
	wire [AW:0]   tx_cnt;
	wire [AW:0]   rx_cnt;
	wire [15:0]   cfg_ibrd = line_cfg[29:14];
	wire [5:0]    cfg_fbrd = line_cfg[13:8];
	wire          pen      = line_cfg[`UFB_LCR_PEN];
	wire          eps      = line_cfg[`UFB_LCR_EPS];
	wire          stp2     = line_cfg[`UFB_LCR_STP2];
	wire [1:0]    wlen     = line_cfg[`UFB_LCR_WLEN_HI:`UFB_LCR_WLEN_LO];
	wire          high_speed_sampling      = serial_control_reg[`UFB_CTL_HSE];
	wire          end_of_transmission_mode      = serial_control_reg[`UFB_CTL_EOT];
	wire          tx_ok    = serial_control_reg[`UFB_CTL_EN] & serial_control_reg[`UFB_CTL_TXE];
	wire          rx_ok    = serial_control_reg[`UFB_CTL_EN] & serial_control_reg[`UFB_CTL_RXE];
	wire [3:0]    os_last  = high_speed_sampling ? `UFB_OS8_LAST : `UFB_OS16_LAST;
	wire [3:0]    os_half  = high_speed_sampling ? `UFB_OS8_HALF : `UFB_OS16_HALF;
	wire [2:0]    wl_last  = 3'h4 + {1'b0, wlen};
	wire [7:0]    wmask    = 8'hff >> (2'h3 - wlen);
	wire          tx_bend  = tick && (tx_sub == os_last);
	wire          rx_samp  = tick && (rx_sub == os_last);
	wire          rxd      = serial_receive_line;
	wire          tx_lvl   = ({1'b0, tx_cnt} <= {1'b0, ufb_level(tx_fifo_level_select)});
	wire          rx_lvl   = ({1'b0, rx_cnt} >= {1'b0, ufb_level(rx_fifo_level_select)});
	wire [6:0]    clr      = int_clear_we ? interrupt_clear_reg : 7'h00;
	// each event group has its own driver process
	wire [6:0]    ev       = {ev_err, ev_rt, ev_lvl};

	// fill level in characters for a level select code
	function [4:0] ufb_level;
		input [2:0] sel;
		begin
			case (sel)
				3'h0:    ufb_level = `UFB_LVL_0;
				3'h1:    ufb_level = `UFB_LVL_1;
				3'h2:    ufb_level = `UFB_LVL_2;
				3'h3:    ufb_level = `UFB_LVL_3;
				default: ufb_level = `UFB_LVL_4;
			endcase
		end
	endfunction

	// ==========================================================
	// control and latched line configuration
	always @(posedge mclk) begin
		if (!rst_b) begin
			serial_control_reg <= `UFB_CTL_RESET;
			line_cfg           <= `UFB_LINE_RESET;
		end else begin
			if (ctl_we) begin
				serial_control_reg <= ctl_wdata;
			end
			// divisor inputs are only sampled here, so a divisor change waits for this write
			if (lcrh_we) begin
				line_cfg <= {baud_integer_divisor, baud_fraction_divisor, lcrh_wdata};
			end
		end
	end

	// ==========================================================
	// submodules
	ufb_baud #(
		.IW (16),
		.FW (6)
	) u_baud (
		.mclk  (mclk),
		.rst_b (rst_b),
		.ibrd  (cfg_ibrd),
		.fbrd  (cfg_fbrd),
		.tick  (tick)
	);

	ufb_fifo #(
		.W     (8),
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_txf (
		.mclk  (mclk),
		.rst_b (rst_b),
		.wr    (tx_wr),
		.wdata (tx_wdata),
		.rd    (tx_rd),
		.rdata (tx_q),
		.count (tx_cnt),
		.full  (tx_full),
		.empty (tx_empty)
	);

	ufb_fifo #(
		.W     (12),
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_rxf (
		.mclk  (mclk),
		.rst_b (rst_b),
		.wr    (rx_wr),
		.wdata (rx_wdata),
		.rd    (rx_rd),
		.rdata (rx_rdata),
		.count (rx_cnt),
		.full  (rx_full),
		.empty (rx_empty)
	);

	// ==========================================================
	// transmitter
	always @(posedge mclk) begin
		if (!rst_b) begin
			tx_st                <= T_IDLE;
			tx_sub               <= 4'h0;
			tx_bit               <= 3'h0;
			tx_sh                <= 8'h00;
			tx_par               <= 1'b0;
			tx_stop2             <= 1'b0;
			tx_rd                <= 1'b0;
			tx_done              <= 1'b0;
			serial_transmit_line <= 1'b1;
		end else begin
			tx_rd   <= 1'b0;
			tx_done <= 1'b0;
			if (tick && !tx_bend) begin
				tx_sub <= tx_sub + 1'b1;
			end
			case (tx_st)
				T_IDLE: begin
					serial_transmit_line <= 1'b1;
					if (tx_ok && !tx_empty) begin
						tx_rd <= 1'b1;
						tx_st <= T_LOAD;
					end
				end
				T_LOAD: begin
					// read data is registered, so wait one cycle after the pop
					if (!tx_rd) begin
						tx_sh                <= tx_q & wmask;
						tx_par               <= (^(tx_q & wmask)) ^ ~eps;
						tx_sub               <= 4'h0;
						serial_transmit_line <= 1'b0;
						tx_st                <= T_START;
					end
				end
				T_START: begin
					if (tx_bend) begin
						tx_sub               <= 4'h0;
						tx_bit               <= 3'h0;
						serial_transmit_line <= tx_sh[0];
						tx_sh                <= {1'b0, tx_sh[7:1]};
						tx_st                <= T_DATA;
					end
				end
				T_DATA: begin
					if (tx_bend) begin
						tx_sub <= 4'h0;
						if (tx_bit == wl_last) begin
							if (pen) begin
								serial_transmit_line <= tx_par;
								tx_st                <= T_PAR;
							end else begin
								serial_transmit_line <= 1'b1;
								tx_stop2             <= stp2;
								tx_st                <= T_STOP;
							end
						end else begin
							tx_bit               <= tx_bit + 1'b1;
							serial_transmit_line <= tx_sh[0];
							tx_sh                <= {1'b0, tx_sh[7:1]};
						end
					end
				end
				T_PAR: begin
					if (tx_bend) begin
						tx_sub               <= 4'h0;
						serial_transmit_line <= 1'b1;
						tx_stop2             <= stp2;
						tx_st                <= T_STOP;
					end
				end
				T_STOP: begin
					// the enables are not looked at here: a started frame always completes
					if (tx_bend) begin
						tx_sub <= 4'h0;
						if (tx_stop2) begin
							tx_stop2 <= 1'b0;
						end else begin
							tx_done <= 1'b1;
							tx_st   <= T_IDLE;
						end
					end
				end
				default: begin
					tx_st <= T_IDLE;
				end
			endcase
		end
	end

	always @(posedge mclk) begin
		if (!rst_b) begin
			busy <= 1'b0;
		end else begin
			busy <= (tx_wr & ~tx_full) | ~tx_empty | (tx_st != T_IDLE);
		end
	end

	// ==========================================================
	// receiver
	always @(posedge mclk) begin
		if (!rst_b) begin
			rx_st    <= R_IDLE;
			rx_sub   <= 4'h0;
			rx_bit   <= 3'h0;
			rx_sh    <= 8'h00;
			rx_pbit  <= 1'b0;
			rx_perr  <= 1'b0;
			rx_prev  <= 1'b1;
			rx_wr    <= 1'b0;
			rx_wdata <= 12'h000;
			oe_pend  <= 1'b0;
			ev_err   <= 4'h0;
		end else begin
			rx_prev <= rxd;
			rx_wr   <= 1'b0;
			ev_err  <= 4'h0;
			if (tick && !rx_samp) begin
				rx_sub <= rx_sub + 1'b1;
			end
			case (rx_st)
				R_IDLE: begin
					if (rx_ok && rx_prev && !rxd) begin
						rx_sub  <= 4'h0;
						rx_sh   <= 8'h00;
						rx_pbit <= 1'b0;
						rx_perr <= 1'b0;
						rx_st   <= R_START;
					end
				end
				R_START: begin
					if (tick && rx_sub == os_half) begin
						rx_sub <= 4'h0;
						rx_bit <= 3'h0;
						// a glitch shorter than half a bit is dropped here
						rx_st  <= rxd ? R_IDLE : R_DATA;
					end
				end
				R_DATA: begin
					if (rx_samp) begin
						rx_sub        <= 4'h0;
						rx_sh[rx_bit] <= rxd;
						if (rx_bit == wl_last) begin
							rx_st <= pen ? R_PAR : R_STOP;
						end else begin
							rx_bit <= rx_bit + 1'b1;
						end
					end
				end
				R_PAR: begin
					if (rx_samp) begin
						rx_sub  <= 4'h0;
						rx_pbit <= rxd;
						rx_perr <= rxd ^ (^rx_sh) ^ ~eps;
						rx_st   <= R_STOP;
					end
				end
				R_STOP: begin
					if (rx_samp) begin
						rx_sub              <= 4'h0;
						rx_st               <= R_IDLE;
						ev_err[`UFB_INT_FE - 3] <= ~rxd;
						ev_err[`UFB_INT_PE - 3] <= rx_perr;
						ev_err[`UFB_INT_BE - 3] <= ~rxd & (rx_sh == 8'h00) & ~rx_pbit;
						if (rx_full) begin
							oe_pend                 <= 1'b1;
							ev_err[`UFB_INT_OE - 3] <= 1'b1;
						end else begin
							rx_wr    <= 1'b1;
							oe_pend  <= 1'b0;
							rx_wdata <= {oe_pend, ~rxd & (rx_sh == 8'h00) & ~rx_pbit, rx_perr, ~rxd, rx_sh};
						end
					end
				end
				default: begin
					rx_st <= R_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// receive timeout, counted in whole bit periods of reference ticks
	always @(posedge mclk) begin
		if (!rst_b) begin
			rt_sub          <= 4'h0;
			rt_cnt          <= 6'h00;
			ev_rt           <= 1'b0;
		end else begin
			ev_rt           <= 1'b0;
			if (rx_empty || rx_wr || rx_rd) begin
				rt_sub <= 4'h0;
				rt_cnt <= 6'h00;
			end else if (tick && rt_cnt != `UFB_RT_BITS) begin
				if (rt_sub == os_last) begin
					rt_sub <= 4'h0;
					rt_cnt <= rt_cnt + 1'b1;
					if (rt_cnt == `UFB_RT_BITS - 6'h01) begin
						ev_rt <= 1'b1;
					end
				end else begin
					rt_sub <= rt_sub + 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// level and end-of-transmission events
	always @(posedge mclk) begin
		if (!rst_b) begin
			// an empty transmit FIFO is at level already: no false edge after reset
			tx_lvl_d            <= 1'b1;
			rx_lvl_d            <= 1'b0;
			ev_lvl[`UFB_INT_RX] <= 1'b0;
			ev_lvl[`UFB_INT_TX] <= 1'b0;
		end else begin
			tx_lvl_d            <= tx_lvl;
			rx_lvl_d            <= rx_lvl;
			ev_lvl[`UFB_INT_RX] <= rx_lvl & ~rx_lvl_d;
			if (end_of_transmission_mode) begin
				ev_lvl[`UFB_INT_TX] <= tx_done & tx_empty;
			end else begin
				ev_lvl[`UFB_INT_TX] <= tx_lvl & ~tx_lvl_d;
			end
		end
	end

	// ==========================================================
	// interrupt status; a new event outranks a clear in the same cycle
	always @* begin
		next_raw = (raw_status_reg & ~clr) | ev;
		if (rx_empty && !ev[`UFB_INT_RT]) begin
			next_raw[`UFB_INT_RT] = 1'b0;
		end
	end

	always @(posedge mclk) begin
		if (!rst_b) begin
			raw_status_reg    <= 7'h00;
			masked_status_reg <= 7'h00;
			irq               <= 1'b0;
		end else begin
			raw_status_reg    <= next_raw;
			masked_status_reg <= next_raw & interrupt_mask_reg;
			irq               <= |(next_raw & interrupt_mask_reg);
		end
	end
endmodule // ufb_uart

/* bench/ufb_uart_assertions.sv */
// assertion checker for the fractional-baud serial port, bound to its top module
`timescale 1ns/1ps
`include "ufb_uart_regs.vh"
module ufb_uart_assertions #(
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input wire        mclk,
	input wire        rst_b,
	input wire        ctl_we,
	input wire [15:0] ctl_wdata,
	input wire [6:0]  interrupt_mask_reg,
	input wire        int_clear_we,
	input wire [6:0]  interrupt_clear_reg,
	input wire        tx_wr,
	input wire        tx_full,
	input wire        tx_empty,
	input wire        rx_empty,
	input wire        busy,
	input wire        serial_transmit_line,
	input wire [15:0] serial_control_reg,
	input wire [6:0]  raw_status_reg,
	input wire [6:0]  masked_status_reg,
	input wire        irq
);
	// ==========================================================
	// timing frame
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);

	sequence s_push;
		tx_wr && !tx_full;
	endsequence
	// three idle cycles leave room for the registered empty flag to catch up
	sequence s_rx_idle;
		rx_empty [*3];
	endsequence

	// ==========================================================
	// properties
	property p_reset_state;
		$rose(rst_b) |-> serial_control_reg == `UFB_CTL_RESET && tx_empty && rx_empty && !busy
			&& serial_transmit_line && raw_status_reg == 7'h00 && !irq;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
	property p_ctl_write;
		ctl_we |=> serial_control_reg == $past(ctl_wdata);
	endproperty
	a_ctl_write: assert property (p_ctl_write) else $error("control write lost");
	property p_masked;
		$stable(interrupt_mask_reg) |-> masked_status_reg == (raw_status_reg & interrupt_mask_reg);
	endproperty
	a_masked: assert property (p_masked) else $error("masked status differs from raw and mask");
	property p_irq_or;
		irq == (|masked_status_reg);
	endproperty
	a_irq_or: assert property (p_irq_or) else $error("request line not the OR of masked sources");
	// the timeout bit is left out: hardware may drop it when the receive side empties
	property p_no_spont_clear;
		$past(rst_b) |-> ((($past(raw_status_reg) & ~raw_status_reg) & 7'h7b
			& ~({7{$past(int_clear_we)}} & $past(interrupt_clear_reg))) == 7'h00);
	endproperty
	a_no_spont_clear: assert property (p_no_spont_clear) else $error("status bit fell uncleared");
	property p_busy_set;
		s_push |=> busy && !tx_empty;
	endproperty
	a_busy_set: assert property (p_busy_set) else $error("busy not set after push");
	property p_busy_hold;
		!tx_empty |-> busy;
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy low with characters queued");
	property p_line_idle;
		!busy |-> serial_transmit_line;
	endproperty
	a_line_idle: assert property (p_line_idle) else $error("transmit line low while idle");
	property p_rt_hw;
		s_rx_idle |-> !raw_status_reg[`UFB_INT_RT];
	endproperty
	a_rt_hw: assert property (p_rt_hw) else $error("timeout set with receive side empty");
endmodule // ufb_uart_assertions

bind ufb_uart ufb_uart_assertions #(.DEPTH(DEPTH), .AW(AW)) u_chk (.*);

/* bench/ufb_remote.sv */
// remote serial device: drives the receive line and decodes frames off the transmit line
`timescale 1ns/1ps
// ==========================================================
// far-side line model
module ufb_remote (
	input  wire  mclk,
	input  wire  serial_transmit_line,
	output logic serial_receive_line
);
	int          bit_cyc = 16;
	int          nbits   = 10;
	logic [11:0] seen[$];

	initial serial_receive_line = 1'h1;

	// bits leave lowest first; the line is released high again after the frame
	task automatic send(input logic [11:0] fr, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge mclk);
			serial_receive_line <= fr[i];
			repeat (bit_cyc - 1) @(posedge mclk);
		end
		@(posedge mclk);
		serial_receive_line <= 1'h1;
	endtask

	task automatic pulse(input int c);
		@(posedge mclk);
		serial_receive_line <= 1'h0;
		repeat (c) @(posedge mclk);
		serial_receive_line <= 1'h1;
	endtask

	// mid-bit sampling from the start edge; bits above the frame stay zero
	always begin
		logic [11:0] v;
		@(negedge serial_transmit_line);
		repeat (bit_cyc / 2) @(posedge mclk);
		v = 12'h000;
		for (int i = 0; i < nbits; i++) begin
			v[i] = serial_transmit_line;
			if (i < nbits - 1)
				repeat (bit_cyc) @(posedge mclk);
		end
		seen.push_back(v);
	end
endmodule // ufb_remote

/* bench/ufb_uart_test.sv */
// self-checking testbench for the fractional-baud serial port
`timescale 1ns/1ps
`include "ufb_uart_regs.vh"
module ufb_uart_test;
	logic        mclk, rst_b, ctl_we, lcrh_we, int_clear_we, tx_wr, rx_rd;
	logic        serial_receive_line, serial_transmit_line, tx_full, tx_empty;
	logic        rx_full, rx_empty, busy, irq;
	logic [15:0] ctl_wdata, baud_integer_divisor, serial_control_reg;
	logic [7:0]  lcrh_wdata, tx_wdata;
	logic [5:0]  baud_fraction_divisor;
	logic [2:0]  tx_fifo_level_select, rx_fifo_level_select;
	logic [6:0]  interrupt_mask_reg, interrupt_clear_reg, raw_status_reg, masked_status_reg;
	logic [11:0] rx_rdata;
	int          err_total = 0;
	int          cmp_count = 0;

	ufb_uart u_dut (.*);
	ufb_remote u_far (.*);

	always #10 mclk = ~mclk;

	// ==========================================================
	// helpers
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic ctl(input logic [15:0] w);
		@(posedge mclk);
		ctl_we <= 1'h1;
		ctl_wdata <= w;
		@(posedge mclk);
		ctl_we <= 1'h0;
	endtask
	// the divisor input is moved away after the latch: only the line write may take it
	task automatic lcr(input logic [7:0] w, input logic [15:0] ib);
		@(posedge mclk);
		lcrh_we <= 1'h1;
		lcrh_wdata <= w;
		baud_integer_divisor <= ib;
		@(posedge mclk);
		lcrh_we <= 1'h0;
		baud_integer_divisor <= ib + 16'h0004;
	endtask
	task automatic iclr(input logic [6:0] m);
		@(posedge mclk);
		int_clear_we <= 1'h1;
		interrupt_clear_reg <= m;
		@(posedge mclk);
		int_clear_we <= 1'h0;
		tick(1);
	endtask
	task automatic push(input logic [7:0] b);
		@(posedge mclk);
		tx_wr <= 1'h1;
		tx_wdata <= b;
		@(posedge mclk);
		tx_wr <= 1'h0;
	endtask
	task automatic popchk(input logic [11:0] exp);
		@(posedge mclk);
		rx_rd <= 1'h1;
		@(posedge mclk);
		rx_rd <= 1'h0;
		#1;
		chk(rx_rdata, exp);
	endtask
	function automatic bit ready(input int w, input int n);
		case (w)
			0: return u_far.seen.size() >= n;
			1: return rx_empty === 1'h0;
			2: return busy === 1'h0;
			default: return serial_transmit_line === 1'h0;
		endcase
	endfunction
	task automatic await(input int w, input int n = 0);
		for (int k = 0; !ready(w, n); k++) begin
			if (k == 20000) begin
				$display("timeout at %0t", $time);
				err_total++;
				tally_and_finish();
			end
			tick(1);
		end
	endtask
	function automatic logic [11:0] fr8(input logic [7:0] d);
		return {3'h1, d, 1'h0};
	endfunction
	function automatic logic [11:0] fr7(input logic [7:0] d);
		return {2'h1, 1'h1, ^d[6:0], d[6:0], 1'h0};
	endfunction
	task automatic report(input string name);
		$display("test %s done: %0d compares, %0d mismatches", name, cmp_count, err_total);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		mclk = 1'h0;
		rst_b = 1'h0;
		ctl_we = 1'h0;
		ctl_wdata = 16'h0000;
		lcrh_we = 1'h0;
		lcrh_wdata = 8'h00;
		baud_integer_divisor = 16'h0000;
		baud_fraction_divisor = 6'h00;
		tx_fifo_level_select = 3'h0;
		rx_fifo_level_select = 3'h0;
		interrupt_mask_reg = 7'h00;
		int_clear_we = 1'h0;
		interrupt_clear_reg = 7'h00;
		tx_wr = 1'h0;
		tx_wdata = 8'h00;
		rx_rd = 1'h0;
		repeat (10) @(posedge mclk);
		rst_b <= 1'h1;
		tick(1);
		chk(serial_control_reg, 16'h0300);
		chk({busy, tx_empty, rx_empty, serial_transmit_line, irq}, 5'h0e);
		report("reset");

		lcr(8'h60, 16'h0001);
		ctl(16'h0301);
		push(8'ha5);
		push(8'h3c);
		tick(1);
		chk(busy, 1'h1);
		await(0, 2);
		chk(u_far.seen.pop_front(), fr8(8'ha5));
		chk(u_far.seen.pop_front(), fr8(8'h3c));
		await(2);
		chk(serial_transmit_line, 1'h1);
		report("send 16x");

		ctl(16'h0300);
		lcr(8'h4e, 16'h0001);
		ctl(16'h0321);
		u_far.bit_cyc = 8;
		u_far.nbits = 11;
		push(8'h6b);
		await(3);
		ctl(16'h0320);
		await(0, 1);
		chk(u_far.seen.pop_front(), fr7(8'h6b));
		await(2);
		chk(busy, 1'h0);
		report("send 8x parity");

		ctl(16'h0300);
		lcr(8'h60, 16'h0001);
		ctl(16'h0301);
		u_far.bit_cyc = 16;
		u_far.nbits = 10;
		u_far.pulse(4);
		tick(300);
		chk(rx_empty, 1'h1);
		u_far.send(fr8(8'h5a), 10);
		await(1);
		popchk(12'h05a);
		iclr(7'h7f);
		u_far.send(12'h066, 10);
		await(1);
		popchk(12'h133);
		chk(raw_status_reg[`UFB_INT_FE], 1'h1);
		chk(irq, 1'h0);
		@(posedge mclk);
		interrupt_mask_reg <= 7'h08;
		tick(2);
		chk(irq, 1'h1);
		chk(masked_status_reg, 7'h08);
		iclr(7'h00);
		chk(raw_status_reg[`UFB_INT_FE], 1'h1);
		iclr(7'h08);
		chk({raw_status_reg[`UFB_INT_FE], irq}, 2'h0);
		u_far.send(12'h000, 10);
		await(1);
		popchk(12'h500);
		chk(raw_status_reg[`UFB_INT_BE], 1'h1);
		report("receive");

		u_far.send(fr8(8'h11), 10);
		await(1);
		tick(30 * 16);
		chk(raw_status_reg[`UFB_INT_RT], 1'h0);
		tick(4 * 16);
		chk(raw_status_reg[`UFB_INT_RT], 1'h1);
		popchk(12'h011);
		tick(2);
		chk(raw_status_reg[`UFB_INT_RT], 1'h0);
		report("timeout");

		iclr(7'h7f);
		for (int i = 0; i < 17; i++) begin
			u_far.send(fr8(i[7:0]), 10);
			if (i == 1) begin
				tick(3);
				chk(raw_status_reg[`UFB_INT_RX], 1'h1);
			end
		end
		tick(3);
		chk(rx_full, 1'h1);
		chk(raw_status_reg[`UFB_INT_OE], 1'h1);
		for (int i = 0; i < 16; i++)
			popchk({4'h0, i[7:0]});
		tick(1);
		chk(rx_empty, 1'h1);
		report("receive fill");

		ctl(16'h0300);
		for (int i = 0; i < 17; i++)
			push(8'h80 + i[7:0]);
		tick(1);
		chk(tx_full, 1'h1);
		iclr(7'h7f);
		ctl(16'h0311);
		await(0, 16);
		for (int i = 0; i < 16; i++)
			chk(u_far.seen.pop_front(), fr8(8'h80 + i[7:0]));
		await(2);
		tick(2);
		chk(raw_status_reg[`UFB_INT_TX], 1'h1);
		chk(u_far.seen.size(), 16'h0000);
		report("send fill");
		tally_and_finish();
	end
endmodule // ufb_uart_test
